// ===== src/eppv_pkg.sv
package eppv_pkg;
    localparam int ADDR_W = 14;
    localparam int DATA_W = 8;
    localparam int HI_ADDR_W = 6;
    localparam int KEY_DEPTH = 64;
    localparam int KEY_AW = 6;
    localparam int CLK_MHZ = 100;
    localparam int PULSE_US = 100;
    localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
    localparam int GAP_US = 10;
    localparam int GAP_CYC = GAP_US * CLK_MHZ;
    localparam int CODE_PULSES = 5;
    localparam int KEY_PULSES = 25;
    localparam logic [DATA_W-1:0] ERASED = 8'hFF;
    localparam logic [ADDR_W-1:0] SIG_LOC0 = 14'h0030;
    localparam logic [ADDR_W-1:0] SIG_LOC1 = 14'h0031;
    localparam logic [ADDR_W-1:0] SIG_LOC2 = 14'h0060;
    // Mode line patterns, bit 4 is line a down to bit 0 line e.
    localparam logic [4:0] MODE_CODE = 5'h0F;
    localparam logic [4:0] MODE_VERIFY = 5'h03;
    localparam logic [4:0] MODE_KEY = 5'h0D;
    localparam logic [4:0] MODE_LOCK1 = 5'h1F;
    localparam logic [4:0] MODE_LOCK2 = 5'h1C;
    localparam logic [4:0] MODE_LOCK3 = 5'h16;
    localparam logic [4:0] MODE_SIG = 5'h00;
    localparam logic [4:0] MODE_VERIFY_MASK = 5'h17;
    typedef enum logic [2:0] {
        EPPV_OP_CODE, EPPV_OP_KEY, EPPV_OP_LOCK1, EPPV_OP_LOCK2,
        EPPV_OP_LOCK3, EPPV_OP_VERIFY, EPPV_OP_SIG
    } eppv_op_t;
endpackage : eppv_pkg

// ===== src/eppv_if.sv
`timescale 1ns/1ps
interface eppv_if;
    logic reset_pin;
    logic program_fetch_strobe;
    logic latch_program_pulse_pin;
    logic supply_high_voltage;
    logic supply_logic_high;
    logic [7:0] low_address_port;
    logic [5:0] high_address_lines;
    logic mode_line_a;
    logic mode_line_b;
    logic mode_line_c;
    logic mode_line_d;
    logic mode_line_e;
    logic [7:0] data_byte_in;
    logic [7:0] data_byte_out;
    logic data_byte_oe;
    logic [7:0] prog_data_out;
    logic prog_data_oe;
    modport device (
        input reset_pin, program_fetch_strobe, latch_program_pulse_pin,
        input supply_high_voltage, supply_logic_high, low_address_port,
        input high_address_lines, mode_line_a, mode_line_b, mode_line_c,
        input mode_line_d, mode_line_e, data_byte_in,
        output data_byte_out, data_byte_oe
    );
    modport programmer (
        output reset_pin, program_fetch_strobe, latch_program_pulse_pin,
        output supply_high_voltage, supply_logic_high, low_address_port,
        output high_address_lines, mode_line_a, mode_line_b, mode_line_c,
        output mode_line_d, mode_line_e, prog_data_out, prog_data_oe,
        input data_byte_in
    );
endinterface : eppv_if

// ===== src/eppv_programmer.sv
`timescale 1ns/1ps
module eppv_programmer #(
    parameter int PULSE_CYCLES = eppv_pkg::PULSE_CYC,
    parameter int GAP_CYCLES = eppv_pkg::GAP_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    eppv_if.programmer pins,
    input wire logic cmd_valid,
    input wire eppv_pkg::eppv_op_t cmd_op,
    input wire logic [13:0] cmd_addr,
    input wire logic [7:0] cmd_data,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_data
);
    typedef enum logic [2:0] {
        EPPV_P_IDLE, EPPV_P_SETUP, EPPV_P_RAISE, EPPV_P_PULSE,
        EPPV_P_GAP, EPPV_P_LOWER, EPPV_P_READ
    } eppv_pst_t;
    eppv_pst_t state;
    eppv_pkg::eppv_op_t op;
    logic [31:0] timer;
    logic [4:0] pulses;
    logic [7:0] rd_s1;
    logic [7:0] rd_s2;

    function automatic logic [4:0] eppv_mode(eppv_pkg::eppv_op_t o);
        case (o)
            eppv_pkg::EPPV_OP_CODE: eppv_mode = eppv_pkg::MODE_CODE;
            eppv_pkg::EPPV_OP_KEY: eppv_mode = eppv_pkg::MODE_KEY;
            eppv_pkg::EPPV_OP_LOCK1: eppv_mode = eppv_pkg::MODE_LOCK1;
            eppv_pkg::EPPV_OP_LOCK2: eppv_mode = eppv_pkg::MODE_LOCK2;
            eppv_pkg::EPPV_OP_LOCK3: eppv_mode = eppv_pkg::MODE_LOCK3;
            eppv_pkg::EPPV_OP_SIG: eppv_mode = eppv_pkg::MODE_SIG;
            default: eppv_mode = eppv_pkg::MODE_VERIFY;
        endcase
    endfunction : eppv_mode

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_s1 <= 8'h00;
            rd_s2 <= 8'h00;
        end else begin
            rd_s1 <= pins.data_byte_in;
            rd_s2 <= rd_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= EPPV_P_IDLE;
            op <= eppv_pkg::EPPV_OP_VERIFY;
            timer <= 32'h0;
            pulses <= 5'h00;
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= 8'h00;
            pins.reset_pin <= 1'b1;
            pins.program_fetch_strobe <= 1'b0;
            pins.latch_program_pulse_pin <= 1'b1;
            pins.supply_high_voltage <= 1'b0;
            pins.supply_logic_high <= 1'b1;
            pins.low_address_port <= 8'h00;
            pins.high_address_lines <= 6'h00;
            {pins.mode_line_a, pins.mode_line_b, pins.mode_line_c,
             pins.mode_line_d, pins.mode_line_e} <= eppv_pkg::MODE_VERIFY;
            pins.prog_data_out <= 8'h00;
            pins.prog_data_oe <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            case (state)
                EPPV_P_IDLE: begin
                    cmd_ready <= 1'b1;
                    if (cmd_valid && cmd_ready) begin
                        cmd_ready <= 1'b0;
                        op <= cmd_op;
                        // Address, data and mode lines all change in the same cycle.
                        {pins.high_address_lines, pins.low_address_port}
                            <= cmd_addr; // [R2] [R9]
                        pins.prog_data_out <= cmd_data; // [R3]
                        pins.prog_data_oe <= cmd_op != eppv_pkg::EPPV_OP_VERIFY
                            && cmd_op != eppv_pkg::EPPV_OP_SIG; // [R3]
                        {pins.mode_line_a, pins.mode_line_b, pins.mode_line_c,
                         pins.mode_line_d, pins.mode_line_e}
                            <= eppv_mode(cmd_op); // [R4] [R5] [R6] [R7] [R8]
                        timer <= 32'(GAP_CYCLES);
                        state <= EPPV_P_SETUP;
                    end
                end
                EPPV_P_SETUP: begin
                    if (timer != 32'h0) begin
                        timer <= timer - 32'h1;
                    end else if (op == eppv_pkg::EPPV_OP_VERIFY
                            || op == eppv_pkg::EPPV_OP_SIG) begin
                        timer <= 32'(GAP_CYCLES); // [R13]
                        state <= EPPV_P_READ;
                    end else begin
                        pins.supply_logic_high <= 1'b0;
                        pins.supply_high_voltage <= 1'b1; // [R12]
                        pulses <= (op == eppv_pkg::EPPV_OP_CODE)
                            ? 5'(eppv_pkg::CODE_PULSES)
                            : 5'(eppv_pkg::KEY_PULSES); // [R10]
                        timer <= 32'(GAP_CYCLES);
                        state <= EPPV_P_RAISE;
                    end
                end
                EPPV_P_RAISE, EPPV_P_GAP: begin
                    if (timer != 32'h0) begin
                        timer <= timer - 32'h1;
                    end else if (pulses == 5'h00) begin
                        timer <= 32'(GAP_CYCLES);
                        state <= EPPV_P_LOWER;
                    end else begin
                        pins.latch_program_pulse_pin <= 1'b0; // [R11]
                        pulses <= pulses - 5'h01;
                        timer <= 32'(PULSE_CYCLES - 1);
                        state <= EPPV_P_PULSE;
                    end
                end
                EPPV_P_PULSE: begin
                    if (timer != 32'h0) begin
                        timer <= timer - 32'h1;
                    end else begin
                        pins.latch_program_pulse_pin <= 1'b1;
                        timer <= 32'(GAP_CYCLES);
                        state <= EPPV_P_GAP;
                    end
                end
                EPPV_P_LOWER: begin
                    pins.supply_high_voltage <= 1'b0;
                    pins.supply_logic_high <= 1'b1; // [R12]
                    if (timer != 32'h0) begin
                        timer <= timer - 32'h1;
                    end else begin
                        pins.prog_data_oe <= 1'b0;
                        rsp_valid <= 1'b1;
                        rsp_data <= 8'h00;
                        state <= EPPV_P_IDLE;
                    end
                end
                EPPV_P_READ: begin
                    if (timer != 32'h0) begin
                        timer <= timer - 32'h1;
                    end else begin
                        rsp_valid <= 1'b1;
                        rsp_data <= rd_s2;
                        state <= EPPV_P_IDLE;
                    end
                end
                default: state <= EPPV_P_IDLE;
            endcase
        end
    end
endmodule : eppv_programmer

// ===== src/eppv_device.sv
`timescale 1ns/1ps
// Functional notes
// [R1] Programmer keeps oscillator at 4 to 6 MHz; here timing assumes a 100 MHz clock (CLK_MHZ).
// [R2] Address: low port plus six high lines.
// [R3] Data port in when programming, out otherwise; the device drives it only in verify and signature reads.
// [R4] Code program mode pattern; low pulse writes.
// [R5] Verify mode pattern selects code readout.
// [R6] Encryption program: code pattern, line d low.
// [R7] Lock bits selected by mode line patterns.
// [R8] Signature read with all mode lines low.
// [R9] Address, data, control, supply, then pulses.
// [R10] Five pulses for code, twenty-five otherwise.
// [R11] Each pulse low for 100 microseconds.
// [R12] Supply raised only around pulsing.
// [R13] Verify only after supply back at logic high.
// [R14] Verify drives addressed byte when unlocked.
// [R15] Verify output is code XNOR encryption byte.
// [R16] Mode line b may strobe verify output.
// [R17] Lock bits never directly readable.
// [R18] Sixty-four encryption bytes, erased to ones.
// [R19] Three lock bits, rising protection.
// [R20] Erase clears array, encryption and locks.
// [R21] Six low address bits pick encryption byte.
// [R22] Lock one stops programming; two stops verify.
// [R23] Signature bytes at three fixed locations.
// [R24] Capture address and data on pulse fall.
module eppv_device #(
    parameter int DEPTH = 16384,
    parameter logic [7:0] SIG_BYTE0 = 8'hA1, // Arbitrary identity value.
    parameter logic [7:0] SIG_BYTE1 = 8'hB2, // Arbitrary identity value.
    parameter logic [7:0] SIG_BYTE2 = 8'hC3 // Arbitrary identity value.
) (
    input wire logic ref_clk,
    input wire logic rst,
    eppv_if.device pins,
    input wire logic erase,
    output logic ext_fetch_block,
    output logic ea_latch_on_reset,
    output logic ext_exec_block
);
    logic [7:0] code_mem [DEPTH];
    logic [7:0] key_mem [eppv_pkg::KEY_DEPTH];
    logic [2:0] lock; // [R19]
    logic [7:0] a_lo_s1, a_lo_s2;
    logic [5:0] a_hi_s1, a_hi_s2;
    logic [7:0] d_s1, d_s2;
    logic [4:0] m_s1, m_s2;
    logic [3:0] c_s1, c_s2;
    logic prog_prev;
    logic [13:0] cap_addr;
    logic [7:0] cap_data;
    logic [4:0] cap_mode;
    logic [13:0] addr;
    logic strap_ok, fetch_low, prog_n, vpp, vcc_hi;
    logic verify_mode, sig_mode, prog_mode;
    logic read_ok;
    logic prog_fall;
    logic prog_rise;
    logic [7:0] verify_byte;

    // Bit positions of the three lock bits and of mode line b.
    localparam int LOCK_ONE = 0;
    localparam int LOCK_TWO = 1;
    localparam int LOCK_THREE = 2;
    localparam int LINE_B = 3;

    assign addr = {a_hi_s2, a_lo_s2}; // [R2]
    assign {strap_ok, fetch_low, prog_n, vpp} = c_s2;
    assign vcc_hi = !vpp;
    // Both read modes need the strap, the strobe, no pulse and logic supply.
    assign read_ok = strap_ok && fetch_low && prog_n && vcc_hi; // [R13]
    assign verify_mode = read_ok
        && ((m_s2 & eppv_pkg::MODE_VERIFY_MASK)
            == eppv_pkg::MODE_VERIFY); // [R5] [R16]
    assign sig_mode = read_ok && m_s2 == eppv_pkg::MODE_SIG; // [R8]
    assign prog_mode = strap_ok && fetch_low && vpp;
    // Pulse edges count only while the programming supply is up.
    assign prog_fall = prog_prev && !prog_n && prog_mode;
    assign prog_rise = !prog_prev && prog_n && prog_mode;
    assign verify_byte = ~(code_mem[addr]
        ^ key_mem[addr[eppv_pkg::KEY_AW-1:0]]); // [R15] [R21]

    ////////////////////////////////////////////////////////////////////
    // Every pin passes two flip-flops before any logic reads it.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            a_lo_s1 <= 8'h00;
            a_lo_s2 <= 8'h00;
            a_hi_s1 <= 6'h00;
            a_hi_s2 <= 6'h00;
            d_s1 <= 8'h00;
            d_s2 <= 8'h00;
            m_s1 <= 5'h00;
            m_s2 <= 5'h00;
            c_s1 <= 4'h2;
            c_s2 <= 4'h2;
        end else begin
            a_lo_s1 <= pins.low_address_port;
            a_lo_s2 <= a_lo_s1;
            a_hi_s1 <= pins.high_address_lines;
            a_hi_s2 <= a_hi_s1;
            d_s1 <= pins.data_byte_in;
            d_s2 <= d_s1;
            m_s1 <= {pins.mode_line_a, pins.mode_line_b, pins.mode_line_c,
                     pins.mode_line_d, pins.mode_line_e};
            m_s2 <= m_s1;
            c_s1 <= {pins.reset_pin, !pins.program_fetch_strobe,
                     pins.latch_program_pulse_pin,
                     pins.supply_high_voltage};
            c_s2 <= c_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Address, data and mode are frozen for the whole low pulse.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prog_prev <= 1'b1;
            cap_addr <= 14'h0000;
            cap_data <= 8'h00;
            cap_mode <= 5'h00;
        end else begin
            prog_prev <= prog_n;
            if (prog_fall) begin
                cap_addr <= addr; // [R24]
                cap_data <= d_s2; // [R24]
                cap_mode <= m_s2;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Writes land on the rising edge that ends the pulse; bits only clear.
    always_ff @(posedge ref_clk) begin
        if (erase) begin
            for (int i = 0; i < DEPTH; i++) begin
                code_mem[i] <= eppv_pkg::ERASED; // [R20]
            end
            for (int i = 0; i < eppv_pkg::KEY_DEPTH; i++) begin
                key_mem[i] <= eppv_pkg::ERASED; // [R18] [R20]
            end
        end else if (prog_rise && !lock[LOCK_ONE]) begin
            if (cap_mode == eppv_pkg::MODE_CODE) begin // [R4] [R22]
                code_mem[cap_addr] <= code_mem[cap_addr] & cap_data;
            end else if (cap_mode == eppv_pkg::MODE_KEY) begin // [R6]
                key_mem[cap_addr[eppv_pkg::KEY_AW-1:0]] <=
                    key_mem[cap_addr[eppv_pkg::KEY_AW-1:0]] & cap_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Erase outranks a lock pulse that ends in the same cycle.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lock <= 3'h0;
        end else if (erase) begin
            lock <= 3'h0; // [R20]
        end else if (prog_rise) begin
            if (cap_mode == eppv_pkg::MODE_LOCK1) begin // [R7]
                lock[LOCK_ONE] <= 1'b1;
            end else if (cap_mode == eppv_pkg::MODE_LOCK2) begin
                lock[LOCK_TWO] <= 1'b1;
            end else if (cap_mode == eppv_pkg::MODE_LOCK3) begin
                lock[LOCK_THREE] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Lock state leaves only as protection enables, never on the data port.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ext_fetch_block <= 1'b0;
            ea_latch_on_reset <= 1'b0;
            ext_exec_block <= 1'b0;
        end else begin
            ext_fetch_block <= lock[LOCK_ONE]; // [R17] [R22]
            ea_latch_on_reset <= lock[LOCK_ONE]; // [R22]
            ext_exec_block <= lock[LOCK_ONE] && lock[LOCK_TWO]
                && lock[LOCK_THREE]; // [R22]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // A released port reads as all ones through the pull-ups.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pins.data_byte_out <= 8'h00;
            pins.data_byte_oe <= 1'b0;
        end else if (sig_mode) begin
            pins.data_byte_oe <= 1'b1; // [R23]
            if (addr == eppv_pkg::SIG_LOC0) begin
                pins.data_byte_out <= SIG_BYTE0;
            end else if (addr == eppv_pkg::SIG_LOC1) begin
                pins.data_byte_out <= SIG_BYTE1;
            end else if (addr == eppv_pkg::SIG_LOC2) begin
                pins.data_byte_out <= SIG_BYTE2;
            end else begin
                pins.data_byte_out <= eppv_pkg::ERASED;
            end
        end else if (verify_mode && !lock[LOCK_TWO] && !m_s2[LINE_B]) begin
            pins.data_byte_oe <= 1'b1; // [R14] [R16] [R22]
            pins.data_byte_out <= verify_byte; // [R15] [R21]
        end else begin
            pins.data_byte_oe <= 1'b0; // [R3]
            pins.data_byte_out <= 8'h00;
        end
    end
endmodule : eppv_device

// ===== testbench/eppv_assertions.sv
`timescale 1ns/1ps
module eppv_assertions #(
    parameter int PULSE_CYCLES = eppv_pkg::PULSE_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic reset_pin,
    input wire logic program_fetch_strobe,
    input wire logic latch_program_pulse_pin,
    input wire logic supply_high_voltage,
    input wire logic supply_logic_high,
    input wire logic [7:0] low_address_port,
    input wire logic [5:0] high_address_lines,
    input wire logic mode_line_a,
    input wire logic mode_line_b,
    input wire logic mode_line_d,
    input wire logic [7:0] prog_data_out,
    input wire logic data_byte_oe
);
    int lo_cnt;
    int pulse_cnt;
    int b_hi_cnt;
    logic lat_prev;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////
    // Counters of pulse width, pulses per high-voltage window and strobe.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lo_cnt <= 0;
            pulse_cnt <= 0;
            b_hi_cnt <= 0;
            lat_prev <= 1'b1;
        end else begin
            lat_prev <= latch_program_pulse_pin;
            lo_cnt <= latch_program_pulse_pin ? 0 : lo_cnt + 1;
            pulse_cnt <= !supply_high_voltage ? 0 :
                pulse_cnt + int'(lat_prev && !latch_program_pulse_pin);
            b_hi_cnt <= !mode_line_b ? 0 : (b_hi_cnt < 4 ? b_hi_cnt + 1 : 4);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_vpp_no_drive: assert property (
        supply_high_voltage |-> !data_byte_oe)
        else $error("device drives data port while programming");
    a_pulse_mode: assert property (
        $fell(latch_program_pulse_pin) |-> reset_pin &&
        !program_fetch_strobe && (mode_line_a || mode_line_b))
        else $error("program pulse outside a program mode");
    a_pulse_under_vpp: assert property (
        !latch_program_pulse_pin |-> supply_high_voltage)
        else $error("program pulse without high voltage");
    a_pulse_width: assert property (
        $rose(latch_program_pulse_pin) |-> lo_cnt == PULSE_CYCLES)
        else $error("program pulse width wrong");
    a_vpp_lead: assert property (
        $rose(supply_high_voltage) |-> latch_program_pulse_pin [*4])
        else $error("pulse too soon after high voltage");
    a_pins_steady: assert property (
        supply_high_voltage && $past(supply_high_voltage) |->
        $stable({high_address_lines, low_address_port, prog_data_out,
        mode_line_a, mode_line_b, mode_line_d}))
        else $error("address, data or mode moved under high voltage");
    a_pulse_count: assert property (
        $fell(supply_high_voltage) |->
        pulse_cnt == ((!mode_line_a && mode_line_d) ? 5 : 25))
        else $error("wrong number of program pulses");
    a_verify_level: assert property (
        data_byte_oe |-> supply_logic_high && !supply_high_voltage &&
        !program_fetch_strobe)
        else $error("device drives data port at wrong supply level");
    a_strobe_float: assert property (
        b_hi_cnt == 4 |-> !data_byte_oe)
        else $error("data port driven with read strobe high");
endmodule : eppv_assertions

// ===== testbench/eppv_tb_top.sv
`timescale 1ns/1ps
module eppv_tb_top;
    localparam int PULSE = 20;
    localparam int GAP = 8;
    // Identity bytes are arbitrary values.
    localparam logic [7:0] SIG0 = 8'h5A;
    localparam logic [7:0] SIG1 = 8'h6B;
    localparam logic [7:0] SIG2 = 8'h7C;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic erase = 1'b0;
    logic cmd_valid = 1'b0;
    eppv_pkg::eppv_op_t cmd_op = eppv_pkg::EPPV_OP_VERIFY;
    logic [13:0] cmd_addr = 14'h0000;
    logic [7:0] cmd_data = 8'h00;
    logic cmd_ready;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic ext_fetch_block;
    logic ea_latch_on_reset;
    logic ext_exec_block;
    logic [7:0] rd;
    logic [13:0] sig_addr [4] = '{14'h0030, 14'h0031, 14'h0060, 14'h0061};
    logic [7:0] sig_exp [4] = '{SIG0, SIG1, SIG2, 8'hFF};
    int n_fail = 0;
    int n_checks = 0;

    always #5 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////
    eppv_if pins ();
    // Programmer drive wins, then the device, else the pull-ups.
    assign pins.data_byte_in = pins.prog_data_oe ? pins.prog_data_out :
        pins.data_byte_oe ? pins.data_byte_out : 8'hFF;

    eppv_programmer #(.PULSE_CYCLES(PULSE), .GAP_CYCLES(GAP))
        i_eppv_programmer (.ref_clk(ref_clk), .rst(rst), .pins(pins),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data));

    eppv_device #(.SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2))
        i_eppv_device (.ref_clk(ref_clk), .rst(rst), .pins(pins),
        .erase(erase), .ext_fetch_block(ext_fetch_block),
        .ea_latch_on_reset(ea_latch_on_reset),
        .ext_exec_block(ext_exec_block));

    eppv_assertions #(.PULSE_CYCLES(PULSE)) i_eppv_assertions (
        .ref_clk(ref_clk), .rst(rst), .reset_pin(pins.reset_pin),
        .program_fetch_strobe(pins.program_fetch_strobe),
        .latch_program_pulse_pin(pins.latch_program_pulse_pin),
        .supply_high_voltage(pins.supply_high_voltage),
        .supply_logic_high(pins.supply_logic_high),
        .low_address_port(pins.low_address_port),
        .high_address_lines(pins.high_address_lines),
        .mode_line_a(pins.mode_line_a), .mode_line_b(pins.mode_line_b),
        .mode_line_d(pins.mode_line_d), .prog_data_out(pins.prog_data_out),
        .data_byte_oe(pins.data_byte_oe));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks=%0d failures=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    // Issues one command, holds it until taken, then waits for the answer.
    task automatic run_cmd(input eppv_pkg::eppv_op_t op,
                           input logic [13:0] addr, input logic [7:0] data);
        int n;
        cmd_op <= op;
        cmd_addr <= addr;
        cmd_data <= data;
        cmd_valid <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 50);
        cmd_valid <= 1'b0;
        check({7'h00, cmd_ready}, 8'h01);
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (rsp_valid !== 1'b1 && n < 2000);
        check({7'h00, rsp_valid}, 8'h01);
        rd = rsp_data;
    endtask : run_cmd

    task automatic verify(input logic [13:0] addr, input logic [7:0] exp);
        run_cmd(eppv_pkg::EPPV_OP_VERIFY, addr, 8'h00);
        check(rd, exp);
    endtask : verify

    // Expected order is exec, latch, fetch.
    task automatic flags(input logic [2:0] exp);
        repeat (4) @(posedge ref_clk);
        check({5'h00, ext_exec_block, ea_latch_on_reset, ext_fetch_block},
              {5'h00, exp});
    endtask : flags

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        erase <= 1'b1;
        @(posedge ref_clk);
        erase <= 1'b0;
        @(posedge ref_clk);
        flags(3'b000);
        verify(14'h3FC5, 8'hFF);
        run_cmd(eppv_pkg::EPPV_OP_CODE, 14'h3FC5, 8'hA5);
        verify(14'h3FC5, 8'hA5);
        run_cmd(eppv_pkg::EPPV_OP_CODE, 14'h0005, 8'h3C);
        verify(14'h0005, 8'h3C);
        verify(14'h1005, 8'hFF);
        run_cmd(eppv_pkg::EPPV_OP_CODE, 14'h0005, 8'hF0);
        verify(14'h0005, 8'h30);
        for (int i = 0; i < 4; i++) begin
            run_cmd(eppv_pkg::EPPV_OP_SIG, sig_addr[i], 8'h00);
            check(rd, sig_exp[i]);
        end
        run_cmd(eppv_pkg::EPPV_OP_KEY, 14'h0005, 8'h0F);
        verify(14'h0005, 8'hC0);
        verify(14'h3FC5, 8'h55);
        verify(14'h1005, 8'h0F);
        verify(14'h0006, 8'hFF);
        run_cmd(eppv_pkg::EPPV_OP_LOCK1, 14'h0000, 8'hFF);
        flags(3'b011);
        verify(14'h0005, 8'hC0);
        run_cmd(eppv_pkg::EPPV_OP_CODE, 14'h0007, 8'h00);
        run_cmd(eppv_pkg::EPPV_OP_KEY, 14'h0007, 8'h00);
        verify(14'h0007, 8'hFF);
        run_cmd(eppv_pkg::EPPV_OP_LOCK2, 14'h0000, 8'hFF);
        flags(3'b011);
        verify(14'h0005, 8'hFF);
        run_cmd(eppv_pkg::EPPV_OP_LOCK3, 14'h0000, 8'hFF);
        flags(3'b111);
        erase <= 1'b1;
        @(posedge ref_clk);
        erase <= 1'b0;
        flags(3'b000);
        verify(14'h0005, 8'hFF);
        verify(14'h3FC5, 8'hFF);
        print_verdict();
    end

    initial begin
        repeat (40000) @(posedge ref_clk);
        n_fail++;
        print_verdict();
    end
endmodule : eppv_tb_top
